// ===== hw/asc_pkg.sv
// package: register map, field positions and timing for the converter control block
`default_nettype none
package asc_pkg;
    // register word addresses on the plain register port
    localparam logic [3:0] ADDR_CTRL1    = 4'h0;
    localparam logic [3:0] ADDR_CTRL2    = 4'h1;
    localparam logic [3:0] ADDR_CTRL3    = 4'h2;
    localparam logic [3:0] ADDR_BUF_BASE = 4'h8;   // 8..15: buffer window, half picked by control three bit 15
    // control register one fields
    localparam int ON_BIT    = 15;
    localparam int IDLE_BIT  = 13;
    localparam int RES_BIT   = 10;
    localparam int FMT_LSB   = 8;
    localparam int TRG_LSB   = 5;
    localparam int SIM_BIT   = 3;
    localparam int AUTO_SAMPLE_START_BIT  = 2;
    localparam int SAMPLE_BIT_BIT  = 1;
    localparam int DONE_BIT  = 0;
    // control register two fields
    localparam int CHP_LSB   = 8;
    localparam int BHS_BIT   = 7;
    localparam int SPI_LSB   = 2;
    localparam int BSM_BIT   = 1;
    localparam int ALT_BIT   = 0;
    // control register three fields
    localparam int SMT_LSB   = 8;
    localparam int DIV_LSB   = 0;
    // writable masks and reset values
    localparam logic [15:0] CTRL1_WMASK = 16'ha7ef;
    localparam logic [15:0] CTRL2_WMASK = 16'he73f;   // bits 12:11 unimplemented
    localparam logic [15:0] CTRL3_WMASK = 16'h9fff;   // bit 15 selects the buffer half that reads see
    localparam logic [15:0] CTRL_RESET  = 16'h0000;
    // trigger source codes
    localparam logic [2:0] TRG_SOFT  = 3'h0;
    localparam logic [2:0] TRG_EXT   = 3'h1;
    localparam logic [2:0] TRG_TMR   = 3'h2;
    localparam logic [2:0] TRG_AUTO  = 3'h7;
    // conversion length in conversion clocks
    localparam int CONV_TAD_10 = 12;
    localparam int CONV_TAD_12 = 14;
    localparam int BUF_WORDS   = 16;

    // sequencer states, gray along idle -> sample -> convert -> store
    typedef enum logic [1:0] {
        ASC_IDLE = 2'b00,
        ASC_SAMPLE_BIT = 2'b01,
        ASC_CONV = 2'b11,
        ASC_STOR = 2'b10
    } asc_state_e;

    // register bus request
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } asc_bus_s;

    // trigger inputs
    typedef struct packed {
        logic tmr3_match;
        logic ext_irq_zero;
    } asc_trig_s;
endpackage
`default_nettype wire

// ===== hw/asc_ctrl.sv
// converter sample and conversion control with register port and result buffer
`timescale 1ns/1ps
`default_nettype none

module asc_ctrl
    import asc_pkg::*;
#(
    parameter int RES_W = 12    // raw converter result width
) (
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic              clk_en_i,
    input  wire asc_bus_s          bus_i,
    output logic [15:0]            rdata_o,
    input  wire asc_trig_s         trig_i,
    input  wire logic              cpu_idle_i,
    input  wire logic [RES_W-1:0]  conv_result_i,   // raw result of the current conversion
    output logic                   sampling_o,      // sample-and-hold amplifiers tracking
    output logic [1:0]             channel_o,       // channel being converted
    output logic                   sample_b_o,      // sample B input selections active
    output logic                   conv_irq_o       // one-cycle conversion interrupt pulse
);
    // the formatter only serves a twelve-bit raw result
    if (RES_W != 12) begin : g_res_chk
        $error("asc_ctrl: RES_W must be 12");
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [15:0]      ctrl1_r, ctrl2_r, ctrl3_r;
    logic [15:0]      buf_r [BUF_WORDS];
    logic [3:0]       wptr_r;
    logic             half_r;
    logic [3:0]       seq_cnt_r;
    logic [7:0]       tad_cnt_r;
    logic [4:0]       smp_cnt_r;
    logic [3:0]       bit_cnt_r;
    logic [1:0]       chan_r;
    logic             alt_r;
    logic             ext_q_r;
    logic             irq_r;
    logic [15:0]      rdata_r;
    asc_state_e       state_r;

    wire logic        run      = ctrl1_r[ON_BIT] & ~(ctrl1_r[IDLE_BIT] & cpu_idle_i);
    wire logic        res12    = ctrl1_r[RES_BIT];
    wire logic [2:0]  trg      = ctrl1_r[TRG_LSB +: 3];
    wire logic        sim_eff  = ctrl1_r[SIM_BIT] & ~res12;
    wire logic [1:0]  chp_eff  = res12 ? 2'h0 : ctrl2_r[CHP_LSB +: 2];
    wire logic [1:0]  last_ch  = chp_eff[1] ? 2'h3 : {1'b0, chp_eff[0]};
    wire logic        tad_tick = run && (tad_cnt_r == ctrl3_r[DIV_LSB +: 8]);
    wire logic        ext_edge = trig_i.ext_irq_zero & ~ext_q_r;
    wire logic        sw_wr1   = bus_i.wr && bus_i.addr == ADDR_CTRL1;

    // result formatting: zero extension or inverted-msb sign fill
    function automatic logic [15:0] fmt_result(input logic [11:0] d, input logic r12, input logic [1:0] f);
        logic [15:0] o;
        o = 16'h0000;
        if (r12) begin
            o = {4'h0, d};
            if (f == 2'h1) o[15:12] = {4{~d[11]}};
        end else begin
            o = {6'h00, d[9:0]};
            if (f == 2'h1) o[15:10] = {6{~d[9]}};
        end
        return o;
    endfunction

    // sampling end condition for the chosen trigger source
    logic sample_bit_end;
    always_comb begin
        unique case (trg)
            TRG_EXT:  sample_bit_end = ext_edge;
            TRG_TMR:  sample_bit_end = trig_i.tmr3_match;
            TRG_AUTO: sample_bit_end = tad_tick && smp_cnt_r == ctrl3_r[SMT_LSB +: 5];
            TRG_SOFT: sample_bit_end = sw_wr1 && !bus_i.wdata[SAMPLE_BIT_BIT];
            default:  sample_bit_end = 1'b0;                                                // reserved codes
        endcase
    end

    wire logic conv_len_done = tad_tick && bit_cnt_r == 4'(res12 ? CONV_TAD_12 - 1 : CONV_TAD_10 - 1);
    wire logic seq_last      = chan_r == last_ch;
    wire logic start_conv    = state_r == ASC_SAMPLE_BIT && sample_bit_end;

    // ----------------------------------------------------------------
    // conversion clock divider
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) tad_cnt_r <= 8'h00;
        // restart at each conversion so it lasts whole conversion clocks
        else if (clk_en_i) tad_cnt_r <= tad_tick || !run || start_conv || (state_r == ASC_STOR && !seq_last)
                                        ? 8'h00 : tad_cnt_r + 8'h01;
    end

    // ----------------------------------------------------------------
    // sequencer: sample, convert each channel, store
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_r   <= ASC_IDLE;
            smp_cnt_r <= 5'h00;
            bit_cnt_r <= 4'h0;
            chan_r    <= 2'h0;
            ext_q_r   <= 1'b0;
        end else if (clk_en_i) begin
            ext_q_r <= trig_i.ext_irq_zero;
            if (!run) begin
                state_r <= ASC_IDLE;
                chan_r  <= 2'h0;
            end else begin
                unique case (state_r)
                    ASC_IDLE: begin
                        smp_cnt_r <= 5'h00;
                        if (ctrl1_r[SAMPLE_BIT_BIT]) state_r <= ASC_SAMPLE_BIT;
                    end
                    ASC_SAMPLE_BIT: begin
                        if (tad_tick) smp_cnt_r <= smp_cnt_r + 5'h01;
                        if (!ctrl1_r[SAMPLE_BIT_BIT] && trg != TRG_SOFT) state_r <= ASC_IDLE;
                        else if (sample_bit_end) begin
                            state_r   <= ASC_CONV;
                            chan_r    <= 2'h0;
                            bit_cnt_r <= 4'h0;
                        end
                    end
                    ASC_CONV: begin
                        if (tad_tick) bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (conv_len_done) state_r <= ASC_STOR;
                    end
                    ASC_STOR: begin
                        // held channels convert one after another either way
                        if (!seq_last) begin
                            chan_r    <= chan_r + 2'h1;
                            bit_cnt_r <= 4'h0;
                            state_r   <= ASC_CONV;
                        end else begin
                            smp_cnt_r <= 5'h00;
                            chan_r    <= 2'h0;
                            state_r   <= ctrl1_r[AUTO_SAMPLE_START_BIT] ? ASC_SAMPLE_BIT : ASC_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // control registers and hardware-owned bits
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ctrl1_r <= CTRL_RESET;
            ctrl2_r <= CTRL_RESET;
            ctrl3_r <= CTRL_RESET;
        end else if (clk_en_i) begin
            if (sw_wr1) begin
                // software writes may only clear done, never set it
                ctrl1_r <= (bus_i.wdata & CTRL1_WMASK) | (ctrl1_r & ~CTRL1_WMASK);
                ctrl1_r[DONE_BIT] <= ctrl1_r[DONE_BIT] & bus_i.wdata[DONE_BIT];
            end
            if (bus_i.wr && bus_i.addr == ADDR_CTRL2) ctrl2_r <= bus_i.wdata & CTRL2_WMASK;
            if (bus_i.wr && bus_i.addr == ADDR_CTRL3) ctrl3_r <= bus_i.wdata & CTRL3_WMASK;
            // hardware events override the software write in the same cycle
            if (start_conv) begin
                ctrl1_r[SAMPLE_BIT_BIT] <= 1'b0;
                ctrl1_r[DONE_BIT] <= 1'b0;
            end
            if (run && state_r == ASC_STOR && seq_last) begin
                ctrl1_r[DONE_BIT] <= 1'b1;
                if (ctrl1_r[AUTO_SAMPLE_START_BIT]) ctrl1_r[SAMPLE_BIT_BIT] <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // result buffer, split halves and interrupt pacing
    // ----------------------------------------------------------------
    wire logic store = run && state_r == ASC_STOR;
    wire logic seq_done = store && seq_last;
    wire logic irq_hit = seq_done && seq_cnt_r == ctrl2_r[SPI_LSB +: 4];
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wptr_r    <= 4'h0;
            half_r    <= 1'b0;
            seq_cnt_r <= 4'h0;
            alt_r     <= 1'b0;
            irq_r     <= 1'b0;
        end else if (clk_en_i) begin
            irq_r <= irq_hit;
            if (store) begin
                buf_r[wptr_r] <= fmt_result(conv_result_i, res12, ctrl1_r[FMT_LSB +: 2]);
                wptr_r        <= wptr_r + 4'h1;
            end
            if (seq_done) begin
                seq_cnt_r <= irq_hit ? 4'h0 : seq_cnt_r + 4'h1;
                alt_r     <= ctrl2_r[ALT_BIT] & ~alt_r;
            end
            if (irq_hit) begin
                half_r <= ctrl2_r[BSM_BIT] & ~half_r;
                wptr_r <= (ctrl2_r[BSM_BIT] & ~half_r) ? 4'h8 : 4'h0;
            end
        end
    end

    // ----------------------------------------------------------------
    // register read port, data one cycle after the read strobe
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) rdata_r <= 16'h0000;
        else if (clk_en_i && bus_i.rd) begin
            unique case (1'b1)
                bus_i.addr == ADDR_CTRL1: begin
                    rdata_r <= ctrl1_r;
                    rdata_r[SIM_BIT] <= sim_eff;
                end
                bus_i.addr == ADDR_CTRL2: begin
                    rdata_r <= ctrl2_r;
                    rdata_r[CHP_LSB +: 2] <= chp_eff;
                    rdata_r[BHS_BIT] <= half_r;
                end
                bus_i.addr == ADDR_CTRL3: rdata_r <= ctrl3_r;
                bus_i.addr >= ADDR_BUF_BASE: rdata_r <= buf_r[{1'b0, bus_i.addr[2:0]} | (ctrl3_r[15] ? 4'h8 : 4'h0)];
                default: rdata_r <= 16'h0000;
            endcase
        end
    end

    assign rdata_o    = rdata_r;
    assign sampling_o = state_r == ASC_SAMPLE_BIT;
    assign channel_o  = chan_r;
    assign sample_b_o = alt_r;
    assign conv_irq_o = irq_r;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_done_start_clr: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        clk_en_i && start_conv |=> !ctrl1_r[DONE_BIT]) else $error("done not cleared at start");
    a_done_set_end: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        clk_en_i && seq_done |=> ctrl1_r[DONE_BIT]) else $error("done not set on completion");
    a_sample_bit_hw_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        clk_en_i && start_conv && trg != TRG_SOFT |=> !ctrl1_r[SAMPLE_BIT_BIT]) else $error("sample bit kept");
    a_off_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        clk_en_i && !ctrl1_r[ON_BIT] |=> state_r == ASC_IDLE) else $error("running while off");
    a_idle_stop: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        clk_en_i && ctrl1_r[IDLE_BIT] && cpu_idle_i |=> state_r == ASC_IDLE) else $error("ran in idle");
    a_sim_reads_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        clk_en_i && bus_i.rd && bus_i.addr == ADDR_CTRL1 && res12 |=> !rdata_o[SIM_BIT]) else $error("sim bit read");
    a_one_chan_12b: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        res12 |-> chan_r == 2'h0) else $error("extra channel in 12-bit");
    a_auto_restart: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        clk_en_i && seq_done && ctrl1_r[AUTO_SAMPLE_START_BIT] |=> state_r == ASC_SAMPLE_BIT && ctrl1_r[SAMPLE_BIT_BIT]) else $error("no restart");
    a_irq_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        clk_en_i && irq_r |=> !irq_r) else $error("interrupt held");
    c_auto_seq: cover property (@(posedge clk_i) seq_done && ctrl1_r[AUTO_SAMPLE_START_BIT]);
    c_split_half: cover property (@(posedge clk_i) irq_hit && half_r);
    c_four_chan: cover property (@(posedge clk_i) store && chan_r == 2'h3);
endmodule
`default_nettype wire

// ===== tb/asc_far_model.sv
// far-side model: timer compare events and the external interrupt pin
`timescale 1ns/1ps
`default_nettype none
module asc_far_model
    import asc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       fire_tmr_i,  // ask for one timer compare event
    input  wire logic       fire_ext_i,  // ask for one rising edge on the pin
    input  wire logic [3:0] lag_i,       // delay before the event, prompt or slow
    output var  asc_trig_s  trig_o
);
    logic [4:0] tmr_cnt_r;
    logic [4:0] ext_cnt_r;

    // event delay counters, both idle at zero
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tmr_cnt_r <= 5'h0;
            ext_cnt_r <= 5'h0;
        end else begin
            tmr_cnt_r <= fire_tmr_i ? {1'b0, lag_i} + 5'h1 : tmr_cnt_r - 5'(tmr_cnt_r != 5'h0);
            ext_cnt_r <= fire_ext_i ? {1'b0, lag_i} + 5'h4 : ext_cnt_r - 5'(ext_cnt_r != 5'h0);
        end
    end

    // match lasts one cycle; pin is high three cycles, otherwise low
    assign trig_o.tmr3_match   = (tmr_cnt_r == 5'h1);
    assign trig_o.ext_irq_zero = (ext_cnt_r != 5'h0) && (ext_cnt_r < 5'h4);
endmodule
`default_nettype wire

// ===== tb/test_adc_sample_convert_control.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module test_adc_sample_convert_control
    import asc_pkg::*;
;
    localparam logic [15:0] B_ON   = 16'h1 << ON_BIT;
    localparam logic [15:0] B_RES  = 16'h1 << RES_BIT;
    localparam logic [15:0] B_SMPL = 16'h1 << SAMPLE_BIT_BIT;
    localparam logic [15:0] B_DONE = 16'h1 << DONE_BIT;
    localparam logic [15:0] B_AUTO = 16'h1 << AUTO_SAMPLE_START_BIT;
    localparam logic [15:0] B_TAUT = 16'(TRG_AUTO) << TRG_LSB;
    localparam logic [15:0] C2_AB  = (16'h1 << ALT_BIT) | (16'h1 << BSM_BIT);
    localparam logic [2:0]  TLIST [4] = '{TRG_EXT, TRG_TMR, TRG_AUTO, 3'h3};
    logic        clk_i;
    logic        sys_rst_i;
    logic        cpu_idle;
    logic        fire_tmr;
    logic        fire_ext;
    logic [3:0]  lag;
    logic [11:0] raw;
    asc_bus_s    bus;
    asc_trig_s   trig;
    logic [15:0] rdata;
    logic        sampling;
    logic [1:0]  channel;
    logic        sample_b;
    logic        irq;
    int          n_errors = 0;
    int          total_checks = 0;
    int          irq_cnt = 0;
    int          gap = 0;
    int          last_gap = 0;
    int          c0;
    int          n;
    integer      seed;
    logic [15:0] d;
    logic [15:0] cfg;
    logic [11:0] q [4];
    bit          got;

    asc_ctrl #(.RES_W(12)) i_asc_ctrl (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1), .bus_i(bus), .rdata_o(rdata),
        .trig_i(trig), .cpu_idle_i(cpu_idle), .conv_result_i(raw), .sampling_o(sampling),
        .channel_o(channel), .sample_b_o(sample_b), .conv_irq_o(irq)
    );
    asc_far_model i_asc_far_model (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .fire_tmr_i(fire_tmr), .fire_ext_i(fire_ext),
        .lag_i(lag), .trig_o(trig)
    );

    // clock, 25 ns period
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // counts interrupts and the cycles since sampling last ended
    always @(posedge clk_i) begin
        if (irq === 1'b1) begin
            irq_cnt <= irq_cnt + 1;
            last_gap <= gap;
        end
        gap <= (sampling === 1'b1) ? 0 : gap + 1;
    end

    function automatic logic [15:0] fmt_exp(input logic hi, input logic sgn, input logic [11:0] r);
        if (hi) return sgn ? {{4{~r[11]}}, r} : {4'h0, r};
        return sgn ? {{6{~r[9]}}, r[9:0]} : {6'h0, r[9:0]};
    endfunction

    task automatic results();
        if (n_errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk_i);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus.wr <= 1'b0;
    endtask

    // read data appear in the cycle after the strobe and hold until the next read
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk_i);
        bus <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic rdc(input logic [3:0] a, input logic [15:0] e);
        logic [15:0] v;
        rd(a, v);
        chk(v, e);
    endtask

    task automatic wait_done();
        logic [15:0] v;
        v = 16'h0;
        for (int i = 0; i < 200 && v[DONE_BIT] !== 1'b1; i++) rd(ADDR_CTRL1, v);
        chk(v & B_DONE, B_DONE);
    endtask

    task automatic wait_irq(input int lim, output bit g);
        int c;
        c = irq_cnt;
        g = 1'b0;
        for (int i = 0; i < lim && !g; i++) begin
            @(posedge clk_i);
            #1 g = (irq_cnt != c);
        end
    endtask

    // watchdog well beyond the expected run length
    initial begin
        #(25 * 40000);
        n_errors++;
        $display("[ERR] %0t run did not finish", $time);
        results();
    end

    initial begin
        seed = 39777;
        {sys_rst_i, cpu_idle, fire_tmr, fire_ext, lag, raw, bus} = {1'b1, 41'h0};
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rdc(ADDR_CTRL1, 16'h0);
        rdc(ADDR_CTRL2, 16'h0);
        wr(4'h3, 16'hffff);
        rdc(4'h3, 16'h0);
        // random register contents with the converter off
        repeat (4) begin
            d = 16'($random(seed));
            wr(ADDR_CTRL3, d);
            rdc(ADDR_CTRL3, d & CTRL3_WMASK);
            wr(ADDR_CTRL2, d);
            rdc(ADDR_CTRL2, d & CTRL2_WMASK);
            d = d & CTRL1_WMASK & ~(B_ON | B_RES | B_SMPL | B_AUTO | B_DONE);
            wr(ADDR_CTRL1, d);
            rdc(ADDR_CTRL1, d);
        end
        // high resolution hides group fields; done cannot be set; off ignores sampling
        wr(ADDR_CTRL2, 16'h3 << CHP_LSB);
        wr(ADDR_CTRL1, B_RES | (16'h1 << SIM_BIT) | B_DONE);
        rdc(ADDR_CTRL1, B_RES);
        rdc(ADDR_CTRL2, 16'h0);
        wr(ADDR_CTRL1, B_SMPL);
        repeat (2) @(posedge clk_i);
        #1 chk({15'h0, sampling}, 16'h0);
        // every resolution and format, four software-ended sequences each
        wr(ADDR_CTRL3, 16'h3);
        wr(ADDR_CTRL2, 16'h3 << SPI_LSB);
        for (int m = 0; m < 4; m++) begin
            cfg = (m[1] ? B_RES : 16'h0) | (m[0] ? 16'h1 << FMT_LSB : 16'h0);
            wr(ADDR_CTRL1, cfg);
            c0 = irq_cnt;
            for (int k = 0; k < 4; k++) begin
                q[k] = 12'($random(seed)) & (m[1] ? 12'hfff : 12'h3ff);
                raw <= q[k];
                wr(ADDR_CTRL1, cfg | B_ON | B_SMPL);
                wr(ADDR_CTRL1, cfg | B_ON);
                rd(ADDR_CTRL1, d);
                chk(d & (B_DONE | B_SMPL), 16'h0);
                chk({13'h0, sample_b, channel}, 16'h0);
                wr(ADDR_CTRL1, cfg | B_ON);
                wait_done();
            end
            n = 4 * (m[1] ? CONV_TAD_12 : CONV_TAD_10);
            chk(16'(irq_cnt - c0), 16'h1);
            chk(16'(last_gap >= n && last_gap <= n + 3), 16'h1);
            for (int k = 0; k < 4; k++) rdc(4'(ADDR_BUF_BASE + k), fmt_exp(m[1], m[0], q[k]));
        end
        // four channels after one shared sample, each stored in turn
        wr(ADDR_CTRL1, 16'h0);
        wr(ADDR_CTRL2, 16'h2 << CHP_LSB);
        wr(ADDR_CTRL1, B_ON | B_SMPL);
        wr(ADDR_CTRL1, B_ON);
        wait_done();
        for (int k = 0; k < 4; k++) rdc(4'(ADDR_BUF_BASE + k), fmt_exp(1'b0, 1'b0, q[3]));
        wr(ADDR_CTRL1, 16'h0);
        // trigger sources, the last one reserved
        wr(ADDR_CTRL3, (16'h2 << SMT_LSB) | 16'h1);
        wr(ADDR_CTRL2, 16'h0);
        foreach (TLIST[i]) begin
            wr(ADDR_CTRL1, B_ON | B_SMPL | (16'(TLIST[i]) << TRG_LSB));
            lag <= 4'($random(seed));
            fire_tmr <= (TLIST[i] != TRG_EXT);
            fire_ext <= (TLIST[i] != TRG_TMR);
            @(posedge clk_i);
            {fire_tmr, fire_ext} <= 2'b00;
            wait_irq(300, got);
            chk({14'h0, got, sampling}, {14'h0, TLIST[i] != 3'h3, TLIST[i] == 3'h3});
            wr(ADDR_CTRL1, 16'h0);
        end
        // idle stop halts the module, otherwise it runs through idle
        cpu_idle <= 1'b1;
        wr(ADDR_CTRL1, B_ON | (16'h1 << IDLE_BIT) | B_TAUT | B_SMPL);
        wait_irq(300, got);
        chk({15'h0, got}, 16'h0);
        cpu_idle <= 1'b0;
        wait_irq(300, got);
        chk({15'h0, got}, 16'h1);
        wr(ADDR_CTRL1, B_ON | B_TAUT | B_SMPL);
        cpu_idle <= 1'b1;
        wait_irq(300, got);
        chk({15'h0, got}, 16'h1);
        cpu_idle <= 1'b0;
        // auto restart with alternating inputs and split buffer
        wr(ADDR_CTRL1, 16'h0);
        wr(ADDR_CTRL2, C2_AB);
        wr(ADDR_CTRL1, B_ON | B_AUTO | B_TAUT | B_SMPL);
        for (int k = 1; k < 4; k++) begin
            wait_irq(300, got);
            repeat (2) @(posedge clk_i);
            #1 chk({13'h0, got, sampling, sample_b}, {13'h0, 2'b11, k[0]});
            rdc(ADDR_CTRL2, C2_AB | (16'(k[0]) << BHS_BIT));
        end
        wr(ADDR_CTRL1, 16'h0);
        results();
    end
endmodule
`default_nettype wire
